/* verilog/swl_defines.svh */
// Timing and size constants for the duty-cycle single-wire link
`ifndef SWL_DEFINES_SVH
`define SWL_DEFINES_SVH

// Clock period in ns (10 MHz)
`define SWL_CLK_NS 100
// Bit period in us, and in clock cycles
`define SWL_BIT_US 1000
`define SWL_BIT_CYC ((`SWL_BIT_US * 1000) / `SWL_CLK_NS)
// Sampling delay after a rising edge, in us and cycles
`define SWL_HALF_US 500
`define SWL_HALF_CYC ((`SWL_HALF_US * 1000) / `SWL_CLK_NS)
// Short high time: at most one fifth of the period (rounds down)
`define SWL_SHORT_CYC (`SWL_BIT_CYC / 5)
// Long high time: at least four fifths of the period (rounds up)
`define SWL_LONG_CYC ((`SWL_BIT_CYC * 4 + 4) / 5)
// Packet length in bits and pattern store depth
`define SWL_PACKET_BITS 8
`define SWL_STORE_BITS 16
// Word sizes of the two receivers
`define SWL_WORD_BITS 8
`define SWL_LINE_STAGES 16
// Reset values
`define SWL_PATTERN_RST 16'h00a5
// Default tap positions of the delay-line side outputs
`define SWL_TAP_A_RST 4'h7
`define SWL_TAP_B_RST 4'h0

`endif

/* verilog/swl_pkg.sv */
// Types shared by both ends of the single-wire link
package swl_pkg;
    // Receiver flavour
    typedef enum logic [1:0] {
        RX_SHIFT = 2'b01,
        RX_LINE = 2'b10
    } rx_kind_t;
    // Transmitter states
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_BIT = 3'b010,
        TX_DONE = 3'b100
    } tx_state_t;
endpackage

/* verilog/swl_if.sv */
// Single-wire link between transmitting end and receiving end
`timescale 1ns/1ns
interface swl_if;
    logic line;
    modport tx_end (output line);
    modport rx_end (input line);
endinterface

/* verilog/swl_delay_line.sv */
// Sixteen-stage serial delay line with three outputs
`timescale 1ns/1ns
`include "swl_defines.svh"
module swl_delay_line #(
    parameter int STAGES = `SWL_LINE_STAGES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Shift strobe and data
    input wire logic shift,
    input wire logic din,
    // Tap selects
    input wire logic [3:0] tap_a_sel,
    input wire logic [3:0] tap_b_sel,
    // Outputs
    output logic last_out,
    output logic tap_a_out,
    output logic tap_b_out
);
    logic [STAGES-1:0] stage_reg;

    // Serial shift only, no parallel view
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            stage_reg <= '0;
        else if (shift)
            stage_reg <= {stage_reg[STAGES-2:0], din};
    end

    // Final stage and two selectable stages
    always_comb
    begin
        last_out = stage_reg[STAGES-1];
        tap_a_out = stage_reg[tap_a_sel];
        tap_b_out = stage_reg[tap_b_sel];
    end
endmodule

/* verilog/swl_tx.sv */
// Transmitting end: pattern store and duty-cycle encoder
`timescale 1ns/1ns
`include "swl_defines.svh"
module swl_tx #(
    parameter int BIT_CYC = `SWL_BIT_CYC,
    parameter int SHORT_CYC = `SWL_SHORT_CYC,
    parameter int LONG_CYC = `SWL_LONG_CYC,
    parameter int PACKET_BITS = `SWL_PACKET_BITS
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Start: pin and host virtual input
    input wire logic ENABLE_PIN,
    input wire logic ENABLE_HOST,
    // Pattern store load
    input wire logic LOAD,
    input wire logic [15:0] PATTERN,
    // Status
    output logic BUSY,
    output logic DONE_IRQ,
    // Link
    swl_if.tx_end LINK
);
    import swl_pkg::*;

    tx_state_t state_reg;
    logic [15:0] pattern_store;
    logic [15:0] bit_period_timer;
    logic [4:0] packet_length_counter;
    logic en_meta;
    logic en_sync;
    logic line_reg;
    logic duty_timing_unit_a;
    logic duty_timing_unit_b;
    logic encode_output_logic;

    // Two flops on the enable pin
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end
        else
        begin
            en_meta <= ENABLE_PIN;
            en_sync <= en_meta;
        end
    end

    // store load
    // Loads whenever the state is not TX_BIT, so a packet in flight is never torn
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            pattern_store <= `SWL_PATTERN_RST;
        else if (LOAD && state_reg != TX_BIT)
            pattern_store <= PATTERN;
    end

    // Sequencer
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state_reg <= TX_IDLE;
            bit_period_timer <= '0;
            packet_length_counter <= '0;
        end
        else
        begin
            case (state_reg)
                TX_IDLE:
                begin
                    if (en_sync || ENABLE_HOST)
                    begin
                        state_reg <= TX_BIT;
                        bit_period_timer <= '0;
                        packet_length_counter <= '0;
                    end
                end
                TX_BIT:
                begin
                    if (bit_period_timer == 16'(BIT_CYC - 1))
                    begin
                        bit_period_timer <= '0;
                        if (packet_length_counter == 5'(PACKET_BITS - 1))
                            state_reg <= TX_DONE;
                        else
                            packet_length_counter <=
                                packet_length_counter + 5'h01;
                    end
                    else
                        bit_period_timer <= bit_period_timer + 16'h0001;
                end
                TX_DONE:
                    state_reg <= TX_IDLE;
                default:
                    state_reg <= TX_IDLE;
            endcase
        end
    end

    always_comb
    begin
        duty_timing_unit_a = bit_period_timer < 16'(SHORT_CYC);
        duty_timing_unit_b = bit_period_timer < 16'(LONG_CYC);
        // duty encodes bit
        // First bit out is the LSB of the store
        encode_output_logic = (state_reg == TX_BIT) &&
            (pattern_store[packet_length_counter[3:0]] ?
             duty_timing_unit_b : duty_timing_unit_a);
    end

    // Registered outputs
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            line_reg <= 1'b0;
            BUSY <= 1'b0;
            DONE_IRQ <= 1'b0;
        end
        else
        begin
            line_reg <= encode_output_logic;
            BUSY <= (state_reg == TX_BIT);
            DONE_IRQ <= (state_reg == TX_DONE);
        end
    end

    assign LINK.line = line_reg;
endmodule

/* verilog/swl_rx.sv */
// Receiving end: shift-register and delay-line receivers
`timescale 1ns/1ns
`include "swl_defines.svh"
module swl_rx #(
    parameter int HALF_CYC = `SWL_HALF_CYC,
    parameter int WORD_BITS = `SWL_WORD_BITS,
    parameter int STAGES = `SWL_LINE_STAGES
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Counter clear pin
    input wire logic CLEAR_PIN,
    // Link
    swl_if.rx_end LINK,
    // Shift-register receiver
    output logic [7:0] WORD,
    output logic WORD_READY,
    // Delay-line receiver
    input wire logic UNLOAD_CLK,
    input wire logic [3:0] TAP_A_SEL,
    input wire logic [3:0] TAP_B_SEL,
    output logic LINE_OUT,
    output logic TAP_A_OUT,
    output logic TAP_B_OUT,
    output logic LINE_READY
);
    import swl_pkg::*;

    logic line_meta;
    logic line_sync;
    logic line_prev;
    logic unl_meta;
    logic unl_sync;
    logic unl_prev;
    logic clr_meta;
    logic clr_sync;
    logic [15:0] half_period_sample_delay;
    logic delay_run;
    logic sample;
    logic [WORD_BITS-1:0] shift_reg;
    logic [3:0] ripple_count;
    logic [4:0] line_count;
    logic unload;
    logic last_w;
    logic tap_a_w;
    logic tap_b_w;

    // Counter wrap check used by both counters
    function automatic logic at_count(input logic [4:0] c, input int n);
        at_count = (c == 5'(n - 1));
    endfunction

    // Two flops on the line, unload and clear inputs; the tap selects are not synchronised
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            line_meta <= 1'b0;
            line_sync <= 1'b0;
            line_prev <= 1'b0;
            unl_meta <= 1'b0;
            unl_sync <= 1'b0;
            unl_prev <= 1'b0;
            clr_meta <= 1'b0;
            clr_sync <= 1'b0;
        end
        else
        begin
            line_meta <= LINK.line;
            line_sync <= line_meta;
            line_prev <= line_sync;
            unl_meta <= UNLOAD_CLK;
            unl_sync <= unl_meta;
            unl_prev <= unl_sync;
            clr_meta <= CLEAR_PIN;
            clr_sync <= clr_meta;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            delay_run <= 1'b0;
            half_period_sample_delay <= '0;
        end
        else if (line_sync && !line_prev)
        begin
            delay_run <= 1'b1;
            half_period_sample_delay <= '0;
        end
        else if (delay_run)
        begin
            if (half_period_sample_delay == 16'(HALF_CYC - 1))
                delay_run <= 1'b0;
            half_period_sample_delay <= half_period_sample_delay + 16'h0001;
        end
    end

    // Sample strobe and unload strobe
    always_comb
    begin
        sample = delay_run &&
            (half_period_sample_delay == 16'(HALF_CYC - 1));
        unload = unl_sync && !unl_prev;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            shift_reg <= '0;
        else if (sample)
            shift_reg <= {line_sync, shift_reg[WORD_BITS-1:1]};
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ripple_count <= '0;
            WORD_READY <= 1'b0;
        end
        else if (clr_sync)
        begin
            ripple_count <= '0;
            WORD_READY <= 1'b0;
        end
        else
        begin
            WORD_READY <= 1'b0;
            if (sample)
            begin
                if (at_count({1'b0, ripple_count}, WORD_BITS))
                begin
                    ripple_count <= '0;
                    WORD_READY <= 1'b1;
                end
                else
                    ripple_count <= ripple_count + 4'h1;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            WORD <= '0;
        else if (sample && at_count({1'b0, ripple_count}, WORD_BITS))
            WORD <= {line_sync, shift_reg[WORD_BITS-1:1]};
    end

    swl_delay_line #(
        .STAGES(STAGES)
    ) u_line (
        .clk(CLK),
        .rst(RST),
        .shift(sample || unload),
        .din(sample ? line_sync : 1'b0),
        .tap_a_sel(TAP_A_SEL),
        .tap_b_sel(TAP_B_SEL),
        .last_out(last_w),
        .tap_a_out(tap_a_w),
        .tap_b_out(tap_b_w)
    );

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            line_count <= '0;
            LINE_READY <= 1'b0;
        end
        else if (clr_sync)
        begin
            line_count <= '0;
            LINE_READY <= 1'b0;
        end
        else if (sample)
        begin
            if (at_count(line_count, STAGES))
            begin
                line_count <= '0;
                LINE_READY <= 1'b1;
            end
            else
            begin
                line_count <= line_count + 5'h01;
                LINE_READY <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            LINE_OUT <= 1'b0;
            TAP_A_OUT <= 1'b0;
            TAP_B_OUT <= 1'b0;
        end
        else
        begin
            LINE_OUT <= last_w;
            TAP_A_OUT <= tap_a_w;
            TAP_B_OUT <= tap_b_w;
        end
    end
endmodule

/* verification/swl_link_props.sv */
// Concurrent checks on the single wire and the status outputs
`timescale 1ns/1ns
module swl_link_props #(
    parameter int BIT_CYC = 50,
    parameter int SHORT_CYC = 10,
    parameter int LONG_CYC = 40,
    parameter int HALF_CYC = 25
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Wire and status
    input wire logic line,
    input wire logic BUSY,
    input wire logic DONE_IRQ,
    input wire logic [7:0] WORD,
    input wire logic WORD_READY,
    input wire logic LINE_READY
);
    logic line_reg;
    logic rose_now;
    logic [15:0] high_reg;
    logic [15:0] since_reg;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    // Rising edge of the wire
    assign rose_now = line && !line_reg;

    // Previous wire level
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            line_reg <= 1'b0;
        else
            line_reg <= line;
    end

    // High run length
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            high_reg <= 16'h0000;
        else
            high_reg <= line ? high_reg + 16'h0001 : 16'h0000;
    end

    // Cycles since last rise; saturates so the first rise is not judged
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            since_reg <= 16'hffff;
        else if (rose_now)
            since_reg <= 16'h0000;
        else if (since_reg != 16'hffff)
            since_reg <= since_reg + 16'h0001;
    end

    sequence done_pulse_s;
        DONE_IRQ ##1 !DONE_IRQ;
    endsequence
    sequence ready_pulse_s;
        WORD_READY ##1 !WORD_READY;
    endsequence

    pulse_width_a:
    assert property ($fell(line) |->
        (high_reg == SHORT_CYC || high_reg == LONG_CYC))
        else $error("high time is neither short nor long");
    slot_period_a:
    assert property (rose_now && since_reg < BIT_CYC |->
        since_reg == BIT_CYC - 1) else $error("bit slot length wrong");
    idle_low_a:
    assert property (line |-> BUSY) else $error("wire high while idle");
    done_once_a:
    assert property (DONE_IRQ |-> done_pulse_s)
        else $error("completion not one cycle");
    done_follows_a:
    assert property ($fell(BUSY) |-> ##[0:3] DONE_IRQ)
        else $error("no completion after packet");
    ready_once_a:
    assert property (WORD_READY |-> ready_pulse_s)
        else $error("word ready not one cycle");
    sample_time_a:
    assert property (WORD_READY |->
        since_reg >= HALF_CYC && since_reg <= HALF_CYC + 6)
        else $error("word ready off mid-slot");
    word_hold_a:
    assert property (!$stable(WORD) |-> WORD_READY)
        else $error("word changed without ready");
    ready_edge_a:
    assert property ($changed(LINE_READY) |->
        since_reg >= HALF_CYC && since_reg <= HALF_CYC + 6)
        else $error("line ready moved off a sample");
endmodule

/* verification/tb_duty_cycle_single_wire_link.sv */
// Self-checking bench for both ends of the single-wire link
`timescale 1ns/1ns
module tb_duty_cycle_single_wire_link;
    // Short slot keeps the run brief
    localparam int BIT = 50;
    localparam int SHORT = 10;
    localparam int LONG = 40;
    localparam int HALF = 25;
    logic clk, rst, en_pin, en_host, load, clear, unload;
    logic busy, done_irq, word_ready, line_out, tap_a, tap_b, line_ready;
    logic [15:0] pattern;
    logic [3:0] tap_sel;
    logic [3:0] tap_b_sel;
    logic [7:0] word;
    int n_mismatch = 0;
    int samples_checked = 0;
    int high_len = 0;
    int n_ready = 0;
    int n_done = 0;
    int runs[$];

    swl_if i_swl_if ();
    swl_tx #(.BIT_CYC(BIT), .SHORT_CYC(SHORT), .LONG_CYC(LONG))
        i_swl_tx (.CLK(clk), .RST(rst), .ENABLE_PIN(en_pin),
        .ENABLE_HOST(en_host), .LOAD(load), .PATTERN(pattern),
        .BUSY(busy), .DONE_IRQ(done_irq), .LINK(i_swl_if.tx_end));
    swl_rx #(.HALF_CYC(HALF)) i_swl_rx (.CLK(clk), .RST(rst),
        .CLEAR_PIN(clear), .LINK(i_swl_if.rx_end), .WORD(word),
        .WORD_READY(word_ready), .UNLOAD_CLK(unload),
        .TAP_A_SEL(tap_sel), .TAP_B_SEL(tap_b_sel), .LINE_OUT(line_out),
        .TAP_A_OUT(tap_a), .TAP_B_OUT(tap_b), .LINE_READY(line_ready));
    swl_link_props #(.BIT_CYC(BIT), .SHORT_CYC(SHORT), .LONG_CYC(LONG),
        .HALF_CYC(HALF)) i_swl_link_props (.CLK(clk), .RST(rst),
        .line(i_swl_if.line), .BUSY(busy), .DONE_IRQ(done_irq),
        .WORD(word), .WORD_READY(word_ready), .LINE_READY(line_ready));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Wire monitor: high run lengths and status pulses
    always @(negedge clk)
    begin
        if (i_swl_if.line === 1'b1)
            high_len++;
        else if (high_len != 0)
        begin
            runs.push_back(high_len);
            high_len = 0;
        end
        if (word_ready === 1'b1)
            n_ready++;
        if (done_irq === 1'b1)
            n_done++;
    end

    // ************************************
    // Shared tasks
    // ************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic send(input logic use_pin, input logic [7:0] exp);
        int i;
        runs.delete();
        n_ready = 0;
        n_done = 0;
        en_pin = use_pin;
        en_host = !use_pin;
        repeat (4) @(negedge clk);
        check({15'h0000, busy}, 16'h0001);
        en_pin = 1'b0;
        en_host = 1'b0;
        i = 0;
        while (n_done == 0 && i < 20 * BIT)
        begin
            @(negedge clk);
            i++;
        end
        repeat (BIT) @(negedge clk);
        check(16'(runs.size()), 16'h0008);
        foreach (runs[k])
            check(16'(runs[k]), exp[k] ? 16'(LONG) : 16'(SHORT));
        check({8'h00, word}, {8'h00, exp});
        check(16'(n_ready), 16'h0001);
        check(16'(n_done), 16'h0001);
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ************************************
    // Scenarios
    // ************************************
    task automatic t_idle();
        repeat (200) @(negedge clk);
        check({15'h0000, busy}, 16'h0000);
        check(16'(runs.size()), 16'h0000);
        check({15'h0000, line_ready}, 16'h0000);
        $display("idle test done");
    endtask

    task automatic t_pin_default();
        send(1'b1, 8'ha5);
        $display("pin start test done");
    endtask

    // Load, then try to overwrite mid-packet
    task automatic t_host_load();
        pattern = 16'hff3c;
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        fork
            send(1'b0, 8'h3c);
            begin
                repeat (100) @(negedge clk);
                pattern = 16'h0000;
                load = 1'b1;
                @(negedge clk);
                load = 1'b0;
            end
        join
        $display("host load test done");
    endtask

    // Unload sixteen bits without touching the bit counter
    task automatic t_unload();
        logic [15:0] bits;
        bits = 16'h3ca5;
        check({15'h0000, line_ready}, 16'h0001);
        for (int k = 0; k < 16; k++)
        begin
            check({15'h0000, line_out}, {15'h0000, bits[k]});
            check({15'h0000, tap_a}, {15'h0000, bits[k]});
            check({15'h0000, tap_b},
                {15'h0000, (k < 9) ? bits[k + 7] : 1'b0});
            unload = 1'b1;
            repeat (4) @(negedge clk);
            unload = 1'b0;
            repeat (4) @(negedge clk);
        end
        check({15'h0000, line_out}, 16'h0000);
        check({15'h0000, line_ready}, 16'h0001);
        $display("unload test done");
    endtask

    task automatic t_clear();
        send(1'b0, 8'h3c);
        check({15'h0000, line_ready}, 16'h0000);
        clear = 1'b1;
        repeat (4) @(negedge clk);
        clear = 1'b0;
        repeat (4) @(negedge clk);
        send(1'b0, 8'h3c);
        check({15'h0000, line_ready}, 16'h0000);
        send(1'b0, 8'h3c);
        check({15'h0000, line_ready}, 16'h0001);
        $display("clear test done");
    endtask

    initial
    begin
        rst = 1'b1;
        en_pin = 1'b0;
        en_host = 1'b0;
        load = 1'b0;
        clear = 1'b0;
        unload = 1'b0;
        pattern = 16'h0000;
        tap_sel = 4'hf;
        // Middle stage, so a broken select cannot mimic the last stage
        tap_b_sel = 4'h8;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        t_idle();
        t_pin_default();
        t_host_load();
        t_unload();
        t_clear();
        give_verdict();
    end

    // Watchdog well beyond the expected few thousand cycles
    initial
    begin
        repeat (20000) @(negedge clk);
        n_mismatch++;
        give_verdict();
    end
endmodule
